// ==== src/fsi_marker.v ====
// One direction of frame start marker generation, stepped per link clock
`timescale 1ns/1ps
module fsi_marker
(
	// Clock, reset, enable
	input  wire       ref_clk_i,
	input  wire       nrst_i,
	input  wire       ce_i,
	// Link clock edge strobe
	input  wire       tick_i,
	// Settings
	input  wire       en_i,
	input  wire       delim_i,
	input  wire       fixed_i,
	input  wire [2:0] width_i,
	input  wire [5:0] delay_i,
	// Frame
	input  wire       frame_i,
	input  wire       sfd_i,
	// Marker
	output reg        marker_o
);

// -----------------------------------------------------------------
// States
// -----------------------------------------------------------------
localparam ST_IDLE  = 5'h01;
localparam ST_ARM   = 5'h02;
localparam ST_DELAY = 5'h04;
localparam ST_ACT   = 5'h08;
localparam ST_HOLD  = 5'h10;

reg  [4:0] state_r;
reg  [6:0] cnt_r;
wire [6:0] limit;
wire       trig_now;

// Width in link cycles is (field + 1) * 8
assign limit    = {1'b0, width_i, 3'h0} + 7'h08;
// Without delimiter mode the first byte or nibble triggers
assign trig_now = !delim_i || sfd_i;

// -----------------------------------------------------------------
// Marker sequencer
// -----------------------------------------------------------------
// Only steps on link clock edges; frame end overrides every state
always @(posedge ref_clk_i)
begin
	if (!nrst_i)
	begin
		state_r  <= ST_IDLE;
		cnt_r    <= 7'h00;
		marker_o <= 1'b0;
	end
	else if (ce_i && tick_i)
	begin
		if (!frame_i)
		begin
			state_r  <= ST_IDLE;
			marker_o <= 1'b0;
		end
		else if (!en_i)
		begin
			state_r  <= ST_HOLD;
			marker_o <= 1'b0;
		end
		else
		begin
			case (state_r)
			ST_IDLE, ST_ARM:
			begin
				if (trig_now)
				begin
					cnt_r <= 7'h01;
					if (delay_i == 6'h00)
					begin
						state_r  <= ST_ACT;
						marker_o <= 1'b1;
					end
					else
						state_r <= ST_DELAY;
				end
				else
					state_r <= ST_ARM;
			end
			ST_DELAY:
			begin
				if (cnt_r == {1'b0, delay_i})
				begin
					state_r  <= ST_ACT;
					marker_o <= 1'b1;
					cnt_r    <= 7'h01;
				end
				else
					cnt_r <= cnt_r + 7'h01;
			end
			ST_ACT:
			begin
				if (fixed_i && cnt_r == limit)
				begin
					state_r  <= ST_HOLD;
					marker_o <= 1'b0;
				end
				else
					cnt_r <= cnt_r + 7'h01;
			end
			ST_HOLD:
				state_r <= ST_HOLD;
			default:
			begin
				state_r  <= ST_IDLE;
				marker_o <= 1'b0;
			end
			endcase
		end
	end
end

endmodule

// ==== src/fsi_regs.vh ====
// Register map and field constants of the frame start indication block
`ifndef FSI_REGS_VH
`define FSI_REGS_VH

// Register indices; byte address is four times the index
`define FSI_IDX_SYNC_CTRL   16'h9427
`define FSI_IDX_MARK_CTRL   16'h9428
`define FSI_IDX_RX_DELAY    16'h9429
`define FSI_IDX_STATUS      16'h9430

// Reset values
`define FSI_RST_SYNC_CTRL   16'h0000
`define FSI_RST_MARK_CTRL   16'h0034
`define FSI_RST_RX_DELAY    16'h0000

// Buffer sync control fields
`define FSI_SYNC_BIT        0

// Marker control fields
`define FSI_TX_EN_BIT       0
`define FSI_RX_EN_BIT       1
`define FSI_DELIM_BIT       2
`define FSI_FIXED_BIT       3
`define FSI_WIDTH_MSB       6
`define FSI_WIDTH_LSB       4
`define FSI_MARK_CTRL_MASK  16'h007F

// Receive delay fields
`define FSI_DEL10_MSB       15
`define FSI_DEL10_LSB       11
`define FSI_DEL100_MSB      10
`define FSI_DEL100_LSB      6
`define FSI_DEL1G_MSB       5
`define FSI_DEL1G_LSB       0

// Status fields
`define FSI_ST_TX_BIT       0
`define FSI_ST_RX_BIT       1
`define FSI_ST_SYNC_BIT     2

// Link speed codes
`define FSI_SPD_10M         2'h0
`define FSI_SPD_100M        2'h1
`define FSI_SPD_1G          2'h2

// Start frame delimiter, byte and nibble forms
`define FSI_SFD_BYTE        8'hD5
`define FSI_SFD_NIBBLE      4'hD

`endif

// ==== src/fsi_top.v ====
// Frame start indication block with Wishbone register slave
// Functional notes
// - Transmit marker enable bit 0 gives a marker per sent frame, else none.
// - Receive marker enable bit 1 gives a marker per received frame, else none.
// - Transmit start is detected after the transmit buffer when it is used.
// - Delimiter bit 2 (reset 1) triggers on SFD, else on first beat.
// - Fixed width bit 3 holds marker a set count, else whole frame.
// - Fixed width lasts (field bits 6:4 plus one) times eight link cycles.
// - Markers always drop no later than the end of their frame.
// - At 10 Mbps receive marker is delayed by field bits 15:11.
// - At 100 Mbps receive marker is delayed by field bits 10:6.
// - At gigabit receive marker is delayed by field bits 5:0.
// - Buffer sync bit 0 selects synchronous buffer, except gigabit timing slave.
`timescale 1ns/1ps
`include "fsi_regs.vh"
module fsi_top
(
	// Clock, reset, enable
	input  wire        ref_clk_i,
	input  wire        nrst_i,
	input  wire        ce_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [31:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output wire        wb_ack_o,
	// Link side, from outside the clock domain
	input  wire        link_clk_i,
	input  wire [1:0]  speed_i,
	input  wire        gig_slave_i,
	input  wire        tx_buf_used_i,
	input  wire        tx_mac_en_i,
	input  wire [7:0]  tx_mac_d_i,
	input  wire        tx_buf_en_i,
	input  wire [7:0]  tx_buf_d_i,
	input  wire        rx_dv_i,
	input  wire [7:0]  rx_d_i,
	// Outputs
	output wire        tx_buf_sync_o,
	output wire        tx_marker_o,
	output wire        rx_marker_o
);

// -----------------------------------------------------------------
// Functions
// -----------------------------------------------------------------
// Delimiter seen as a byte at gigabit, as a nibble below
// Below gigabit only the low nibble carries data, so the upper
// nibble of the data bus is ignored there on purpose.
// Shared by both directions, hence a function and not inline logic.
function fsi_is_sfd;
	input [7:0] d;
	input       gig;
	begin
		if (gig)
			fsi_is_sfd = (d == `FSI_SFD_BYTE);
		else
			fsi_is_sfd = (d[3:0] == `FSI_SFD_NIBBLE);
	end
endfunction

// -----------------------------------------------------------------
// Input synchronisers
// -----------------------------------------------------------------
// Every link pin is asynchronous to the system clock, so the whole
// bundle is flopped twice before any logic looks at it.
// Data and enables move half a link period ahead of the link clock
// edge, so they are settled by the time the synced edge is found.
// Limitation: the link clock must stay below half the system clock,
// otherwise edges are lost between two samples.
localparam SW = 32;

reg  [SW-1:0] sync1_r;
reg  [SW-1:0] sync2_r;
reg           link_clk3_r;
wire [SW-1:0] raw;
wire          tick;

// Pin bundle, most significant first; widths add up to SW
assign raw = {
	link_clk_i,     // 31
	speed_i,        // 30:29
	gig_slave_i,    // 28
	tx_buf_used_i,  // 27
	tx_mac_en_i,    // 26
	tx_mac_d_i,     // 25:18
	tx_buf_en_i,    // 17
	tx_buf_d_i,     // 16:9
	rx_dv_i,        // 8
	rx_d_i          // 7:0
};

// Two flops for every pin; the third clock flop only finds edges
always @(posedge ref_clk_i)
begin
	if (!nrst_i)
	begin
		sync1_r     <= {SW{1'b0}};
		sync2_r     <= {SW{1'b0}};
		link_clk3_r <= 1'b0;
	end
	else if (ce_i)
	begin
		sync1_r     <= raw;
		sync2_r     <= sync1_r;
		link_clk3_r <= sync2_r[31];
	end
end

// Synced copies, split back into their fields
// Only these copies are read by the logic below, never the first stage
wire       link_clk_s  = sync2_r[31];
wire [1:0] speed_s     = sync2_r[30:29];
wire       gig_slave_s = sync2_r[28];
wire       buf_used_s  = sync2_r[27];
wire       mac_en_s    = sync2_r[26];
wire [7:0] mac_d_s     = sync2_r[25:18];
wire       buf_en_s    = sync2_r[17];
wire [7:0] buf_d_s     = sync2_r[16:9];
wire       rx_dv_s     = sync2_r[8];
wire [7:0] rx_d_s      = sync2_r[7:0];

// Rising edge of the link clock
// The edge flop resets low like the synced clock, so no tick is seen
// during reset; a pin already high at release still gives a first tick.
assign tick = link_clk_s && !link_clk3_r;

// -----------------------------------------------------------------
// Registers
// -----------------------------------------------------------------
reg  [15:0] sync_ctrl_r;
reg  [15:0] mark_ctrl_r;
reg  [15:0] rx_delay_r;
reg         ack_r;
wire [15:0] idx;
wire        req;
wire        gig;
wire        sync_eff;

// Register index from the byte address; the two low bits select a
// byte inside the word and are covered by the lane enables instead.
// Address bits above 17 are not decoded, so the map repeats above.
assign idx      = wb_adr_i[17:2];
assign req      = wb_cyc_i && wb_stb_i && !ack_r;
assign wb_ack_o = ack_r;
assign gig      = (speed_s == `FSI_SPD_1G);

assign sync_eff = sync_ctrl_r[`FSI_SYNC_BIT] && !(gig && gig_slave_s);
assign tx_buf_sync_o = sync_eff;

// Write side; sel lane 0 and 1 carry the 16-bit registers
// Reserved bits are never stored, so they cannot leak into reads.
// The ack flop blocks a take of the same request in the ack cycle only,
// so a strobe held past the ack writes again in the cycle after it.
always @(posedge ref_clk_i)
begin
	if (!nrst_i)
	begin
		sync_ctrl_r <= `FSI_RST_SYNC_CTRL;
		mark_ctrl_r <= `FSI_RST_MARK_CTRL;
		rx_delay_r  <= `FSI_RST_RX_DELAY;
	end
	else if (ce_i && req && wb_we_i)
	begin
		case (idx)
		`FSI_IDX_SYNC_CTRL:
			if (wb_sel_i[0])
				sync_ctrl_r[0] <= wb_dat_i[0];
		`FSI_IDX_MARK_CTRL:
			if (wb_sel_i[0])
				mark_ctrl_r[6:0] <= wb_dat_i[6:0];
		`FSI_IDX_RX_DELAY:
		begin
			if (wb_sel_i[0])
				rx_delay_r[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				rx_delay_r[15:8] <= wb_dat_i[15:8];
		end
		default:
			sync_ctrl_r <= sync_ctrl_r;
		endcase
	end
end

// One-cycle ack and registered read data; unmapped reads give zero
// Read data stays put until the next read, which costs a little
// area but lets a slow master take it any time after the ack.
// Unmapped indices are still acked so a stray access never hangs.
always @(posedge ref_clk_i)
begin
	if (!nrst_i)
	begin
		ack_r    <= 1'b0;
		wb_dat_o <= 32'h0000_0000;
	end
	else if (ce_i)
	begin
		ack_r <= req;
		if (req && !wb_we_i)
		begin
			case (idx)
			`FSI_IDX_SYNC_CTRL:
				wb_dat_o <= {16'h0000, sync_ctrl_r};
			`FSI_IDX_MARK_CTRL:
				wb_dat_o <= {16'h0000,
					mark_ctrl_r & `FSI_MARK_CTRL_MASK};
			`FSI_IDX_RX_DELAY:
				wb_dat_o <= {16'h0000, rx_delay_r};
			`FSI_IDX_STATUS:
				wb_dat_o <= {29'h0000_0000, sync_eff,
					rx_marker_o, tx_marker_o};
			default:
				wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
end

// -----------------------------------------------------------------
// Frame sources and settings per direction
// -----------------------------------------------------------------
reg  [5:0] rx_del;
wire [1:0] dir_en;
wire [1:0] dir_frame;
wire [1:0] dir_sfd;
wire [5:0] dir_delay [0:1];
wire [1:0] dir_mark;
wire       tx_frame;
wire [7:0] tx_data;

// Detect after the buffer when used
assign tx_frame = buf_used_s ? buf_en_s : mac_en_s;
assign tx_data  = buf_used_s ? buf_d_s : mac_d_s;

// Receive delay picked by link speed
// The narrower fields are zero extended; speed code 3 has no field
// and gives no delay. The speed pin may move only with the link down.
always @*
begin
	case (speed_s)
	`FSI_SPD_10M:
		rx_del = {1'b0, rx_delay_r[`FSI_DEL10_MSB:`FSI_DEL10_LSB]};
	`FSI_SPD_100M:
		rx_del = {1'b0, rx_delay_r[`FSI_DEL100_MSB:`FSI_DEL100_LSB]};
	`FSI_SPD_1G:
		rx_del = rx_delay_r[`FSI_DEL1G_MSB:`FSI_DEL1G_LSB];
	default:
		rx_del = 6'h00;
	endcase
end

assign dir_en[0]    = mark_ctrl_r[`FSI_TX_EN_BIT];
assign dir_en[1]    = mark_ctrl_r[`FSI_RX_EN_BIT];
assign dir_frame[0] = tx_frame;
assign dir_frame[1] = rx_dv_s;
assign dir_sfd[0]   = fsi_is_sfd(tx_data, gig);
assign dir_sfd[1]   = fsi_is_sfd(rx_d_s, gig);
// Transmit side has no assertion delay in this block
assign dir_delay[0] = 6'h00;
assign dir_delay[1] = rx_del;

// -----------------------------------------------------------------
// Marker generators
// -----------------------------------------------------------------
// One generator per direction: index 0 transmit, index 1 receive.
// Both share the width and mode bits but keep their own counters,
// so a frame in one direction never disturbs the other.
// Markers leave flops, so they are glitch free at the pins.
// Width field feeds each generator
genvar g;
generate
	for (g = 0; g < 2; g = g + 1)
	begin : gen_dir
		fsi_marker u_marker
		(
			.ref_clk_i (ref_clk_i),
			.nrst_i    (nrst_i),
			.ce_i      (ce_i),
			.tick_i    (tick),
			.en_i      (dir_en[g]),
			.delim_i   (mark_ctrl_r[`FSI_DELIM_BIT]),
			.fixed_i   (mark_ctrl_r[`FSI_FIXED_BIT]),
			.width_i   (mark_ctrl_r[`FSI_WIDTH_MSB:`FSI_WIDTH_LSB]),
			.delay_i   (dir_delay[g]),
			.frame_i   (dir_frame[g]),
			.sfd_i     (dir_sfd[g]),
			.marker_o  (dir_mark[g])
		);
	end
endgenerate

// Marker outputs, straight from the generator flops
assign tx_marker_o = dir_mark[0];
assign rx_marker_o = dir_mark[1];

endmodule

// ==== verif/fsi_checker.sv ====
// Port checker of the frame start indication block
`timescale 1ns/1ps
module fsi_checker
(
	// Clock, reset, bus
	input wire        ref_clk_i,
	input wire        nrst_i,
	input wire        ce_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_ack_o,
	input wire [31:0] wb_dat_o,
	// Link side
	input wire [1:0]  speed_i,
	input wire        gig_slave_i,
	input wire        tx_buf_used_i,
	input wire        tx_mac_en_i,
	input wire        tx_buf_en_i,
	input wire        rx_dv_i,
	input wire        tx_buf_sync_o,
	input wire        tx_marker_o,
	input wire        rx_marker_o
);
	// ----
	// Frame idle ages
	// ----
	logic [5:0] rx_idle_r;
	logic [5:0] tx_idle_r;
	wire        tx_fr = tx_buf_used_i ? tx_buf_en_i : tx_mac_en_i;
	// Saturate, so a long gap never wraps back to young
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i || rx_dv_i)
			rx_idle_r <= nrst_i ? 6'h00 : 6'h3F;
		else if (rx_idle_r != 6'h3F)
			rx_idle_r <= rx_idle_r + 6'h01;
		if (!nrst_i || tx_fr)
			tx_idle_r <= nrst_i ? 6'h00 : 6'h3F;
		else if (tx_idle_r != 6'h3F)
			tx_idle_r <= tx_idle_r + 6'h01;
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	endsequence
	sequence s_slave;
		(gig_slave_i && speed_i == 2'h2)[*4];
	endsequence
	a_ack_answer: assert property (s_req |=> wb_ack_o)
		else $error("bus ack late");
	a_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("bus ack too long");
	a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read half set");
	a_tx_rise_frame: assert property ($rose(tx_marker_o) |-> tx_idle_r < 6'h08)
		else $error("tx marker outside frame");
	a_rx_rise_frame: assert property ($rose(rx_marker_o) |-> rx_idle_r < 6'h08)
		else $error("rx marker outside frame");
	a_rx_drop_end: assert property (rx_idle_r > 6'h18 |-> !rx_marker_o)
		else $error("rx marker past frame");
	a_tx_drop_end: assert property (tx_idle_r > 6'h18 |-> !tx_marker_o)
		else $error("tx marker past frame");
	a_sync_slave: assert property (s_slave |-> !tx_buf_sync_o)
		else $error("sync buffer in slave mode");
endmodule
bind fsi_top fsi_checker chk_u (.*);

// ==== verif/fsi_link_model.sv ====
// Link partner model: free link clock and frames on one path
`timescale 1ns/1ps
module fsi_link_model
(
	// Clock and frame state
	output logic       link_clk_o,
	output logic       busy_o,
	// Frame lines
	output logic       rx_dv_o,
	output logic [7:0] rx_d_o,
	output logic       tx_mac_en_o,
	output logic [7:0] tx_mac_d_o,
	output logic       tx_buf_en_o,
	output logic [7:0] tx_buf_d_o
);
	// Link clock runs free, as a line clock does
	initial
	begin
		{link_clk_o, busy_o, rx_dv_o, tx_mac_en_o, tx_buf_en_o} = 5'h00;
		{rx_d_o, tx_mac_d_o, tx_buf_d_o} = 24'h000000;
		forever #62.5 link_clk_o = ~link_clk_o;
	end
	// One beat; lines move on the falling edge, away from sampling
	task automatic put(input logic [1:0] p, input logic e, input logic [7:0] b);
		@(negedge link_clk_o);
		busy_o = e;
		case (p)
			2'h2: {rx_dv_o, rx_d_o} = {e, b};
			2'h1: {tx_buf_en_o, tx_buf_d_o} = {e, b};
			default: {tx_mac_en_o, tx_mac_d_o} = {e, b};
		endcase
	endtask
	// Preamble, delimiter, body; idle data is the last beat inverted
	task automatic frame(input logic [1:0] p, input int pre, input int len,
		input logic [7:0] sfd);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < pre + 1 + len; i++)
		begin
			b = (i < pre) ? 8'h55 : (i == pre) ? sfd : 8'(i);
			put(p, 1'b1, b);
		end
		put(p, 1'b0, ~b);
	endtask
endmodule

// ==== verif/tb_frame_start_indication.sv ====
// Self-checking bench of the frame start indication block
`timescale 1ns/1ps
`include "fsi_regs.vh"
module tb_frame_start_indication;
	logic        ref_clk_i, nrst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [31:0] wb_adr_i, wb_dat_i, q;
	logic [3:0]  wb_sel_i;
	logic [1:0]  speed_i, path;
	logic        gig_slave_i, tx_buf_used_i;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, tx_buf_sync_o, tx_marker_o, rx_marker_o, busy;
	wire         link_clk_i, rx_dv_i, tx_mac_en_i, tx_buf_en_i;
	wire  [7:0]  rx_d_i, tx_mac_d_i, tx_buf_d_i;
	int          n_errors = 0, total_checks = 0, beat, first, wid;
	typedef struct packed {logic [15:0] ctrl, dly; logic [1:0] spd, path;
		logic [7:0] sfd, first, wid;} fsi_row_t;
	fsi_row_t    r;
	// Frame: 7 preamble, delimiter, 20 body beats; path 2 rx, 1 buffer
	fsi_row_t    rows [8] = '{
		'{16'h000D, 16'h0843, 2'h2, 2'h0, 8'hD5, 8'h08, 8'h08},
		'{16'h0006, 16'h0843, 2'h2, 2'h2, 8'hD5, 8'h0B, 8'h11},
		'{16'h001A, 16'h0000, 2'h2, 2'h2, 8'hD5, 8'h01, 8'h10},
		'{16'h000D, 16'h0000, 2'h2, 2'h2, 8'hD5, 8'h00, 8'h00},
		'{16'h007E, 16'h1885, 2'h1, 2'h2, 8'h0D, 8'h0A, 8'h12},
		'{16'h0006, 16'h0900, 2'h0, 2'h2, 8'h0D, 8'h09, 8'h13},
		'{16'h0005, 16'h0000, 2'h2, 2'h1, 8'hD5, 8'h08, 8'h14},
		'{16'h0005, 16'h0000, 2'h2, 2'h3, 8'hD5, 8'h00, 8'h00}};
	wire         mk = (path == 2'h2) ? rx_marker_o : tx_marker_o;
	fsi_top dut_u (.*);
	fsi_link_model lm (.link_clk_o(link_clk_i), .busy_o(busy),
		.rx_dv_o(rx_dv_i), .rx_d_o(rx_d_i), .tx_mac_en_o(tx_mac_en_i),
		.tx_mac_d_o(tx_mac_d_i), .tx_buf_en_o(tx_buf_en_i),
		.tx_buf_d_o(tx_buf_d_i));
	// Marker sampled at link edges, well clear of its ref-clock moves
	always @(posedge link_clk_i)
	if (busy)
	begin
		if (mk && first == 0)
			first = beat;
		if (mk)
			wid++;
		beat++;
	end
	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task rst;
		nrst_i <= 1'b0;
		repeat (10) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
	endtask
	// Classic single cycle, held until ack is sampled
	task wb(input logic we, input logic [15:0] idx, input logic [15:0] d);
		int i;
		@(posedge ref_clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
		wb_adr_i <= {14'h0000, idx, 2'h0};
		wb_dat_i <= {16'h0000, d};
		i = 0;
		do
		begin
			@(posedge ref_clk_i);
			i++;
		end
		while (wb_ack_o !== 1'b1 && i < 20);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		if (wb_ack_o !== 1'b1)
		begin
			n_errors++;
			end_of_test;
		end
	endtask
	initial
	begin
		#200000;
		n_errors++;
		end_of_test;
	end
	initial
	begin
		{nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, gig_slave_i} = 5'h00;
		{wb_adr_i, wb_dat_i, tx_buf_used_i, path} = 67'h0;
		{wb_sel_i, speed_i, ce_i} = 7'h7D;
		rst;
		foreach (rows[k])
		begin
			r = rows[k];
			{speed_i, path, tx_buf_used_i} <= {r.spd, r.path, r.path[0]};
			wb(1'b1, `FSI_IDX_MARK_CTRL, 16'h0000);
			wb(1'b1, `FSI_IDX_MARK_CTRL, r.ctrl);
			wb(1'b1, `FSI_IDX_RX_DELAY, r.dly);
			{beat, first, wid} = 96'h0;
			lm.frame(r.path, 7, 20, r.sfd);
			chk("first", 32'(first), 32'(r.first));
			chk("width", 32'(wid), 32'(r.wid));
			$display("row %0d done", k);
		end
		rst;
		wb(1'b0, `FSI_IDX_MARK_CTRL, 16'h0000);
		chk("ctrl reset", q, 32'h00000034);
		wb(1'b0, `FSI_IDX_RX_DELAY, 16'h0000);
		chk("delay reset", q, 32'h00000000);
		wb(1'b1, `FSI_IDX_MARK_CTRL, 16'h0006);
		fork
			lm.frame(2'h2, 7, 20, 8'hD5);
			begin
				repeat (150) @(posedge ref_clk_i);
				chk("rx up", 32'(rx_marker_o), 32'h00000001);
				wb(1'b1, `FSI_IDX_MARK_CTRL, 16'h0004);
				repeat (30) @(posedge ref_clk_i);
				chk("rx killed", 32'(rx_marker_o), 32'h00000000);
			end
		join
		$display("enable drop done");
		wb(1'b1, `FSI_IDX_MARK_CTRL, 16'hFFFF);
		wb(1'b0, `FSI_IDX_MARK_CTRL, 16'h0000);
		chk("ctrl reserved", q, 32'h0000007F);
		wb(1'b1, 16'h9431, 16'hFFFF);
		wb(1'b0, 16'h9431, 16'h0000);
		chk("unmapped", q, 32'h00000000);
		wb(1'b1, `FSI_IDX_SYNC_CTRL, 16'h0001);
		gig_slave_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		chk("sync slave", 32'(tx_buf_sync_o), 32'h00000000);
		gig_slave_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		chk("sync on", 32'(tx_buf_sync_o), 32'h00000001);
		wb(1'b0, `FSI_IDX_STATUS, 16'h0000);
		chk("status", q, 32'h00000004);
		$display("register tests done");
		end_of_test;
	end
endmodule
